// file: write_and_mark_invalid_cmd_decode.v
// Our own choices: the Wishbone register port and the address map.
`include "wuc_defines.vh"

module write_and_mark_invalid_cmd_decode (
	input  wire        clk_in,
	input  wire        rst_n_in,
	input  wire        cmd_valid_in,
	output wire        cmd_ready_out,
	input  wire [7:0]  cmd_opcode_in,
	input  wire [15:0] cmd_id_in,
	input  wire [15:0] cmd_sqid_in,
	input  wire [31:0] cdw10_in,
	input  wire [31:0] cdw11_in,
	input  wire [31:0] cdw12_in,
	input  wire [31:0] cdw13_in,
	input  wire [31:0] cdw14_in,
	input  wire [31:0] cdw15_in,
	output reg         cpl_valid_out,
	input  wire        cpl_ready_in,
	output reg  [15:0] cpl_cmd_id_out,
	output reg  [15:0] cpl_sqid_out,
	output reg  [2:0]  cpl_sct_out,
	output reg  [7:0]  cpl_sc_out,
	output reg  [63:0] media_addr_out,
	output reg  [15:0] media_count_out,
	output reg  [31:0] ref_tag_out,
	output reg  [15:0] app_tag_mask_out,
	output reg  [15:0] app_tag_value_out,
	output reg  [3:0]  freq_hint_out,
	output reg         low_latency_out,
	input  wire [5:0]  wb_adr_in,
	input  wire [31:0] wb_dat_in,
	output reg  [31:0] wb_dat_out,
	input  wire        wb_we_in,
	input  wire [3:0]  wb_sel_in,
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	output reg         wb_ack_out
);

	// ****************************************
	// reset release
	// ****************************************
	reg rst_meta;
	reg rst_n;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	function [`MAP_ADDR_W-1:0] map_index;
		input [63:0] lba;
		begin
			map_index = lba[`MAP_ADDR_W-1:0];
		end
	endfunction

	// zero-based count: the step with nothing left is the last block
	function last_step;
		input [15:0] left;
		begin
			last_step = (left == 16'h0000);
		end
	endfunction

	function [63:0] lba_plus_one;
		input [63:0] lba;
		begin
			lba_plus_one = lba + 64'h0000000000000001;
		end
	endfunction

	function [15:0] count_minus_one;
		input [15:0] left;
		begin
			count_minus_one = left - 16'h0001;
		end
	endfunction

	// byte lanes not selected keep their old contents
	function [31:0] merge_bytes;
		input [31:0] old;
		input [31:0] din;
		input [3:0]  sel;
		integer      i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge_bytes[i*8 +: 8] = sel[i] ? din[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction

	// ****************************************
	// state machine
	// ****************************************
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_WALK = 5'b00010;
	localparam [4:0] ST_WAIT = 5'b00100;
	localparam [4:0] ST_CHK  = 5'b01000;
	localparam [4:0] ST_CPL  = 5'b10000;

	reg  [4:0]  state;
	reg  [7:0]  opcode;
	reg  [63:0] cur_lba;
	reg  [15:0] remain;
	reg  [31:0] ctrl;
	reg  [31:0] cmd_count;
	wire        map_rd;
	reg         map_we;
	reg         map_wdata;

	wire prot_en = ctrl[`CTRL_PROT_BIT];
	wire [3:0] prinfo = cdw12_in[`PRINFO_MSB:`PRINFO_LSB];
	wire [7:0] hint   = cdw13_in[`HINT_MSB:`HINT_LSB];
	// reserved frequency codes are dropped to "none" downstream
	wire [3:0] freq   = (hint[`FREQ_MSB:`FREQ_LSB] > `FREQ_LAST_VALID) ?
		4'h0 : hint[`FREQ_MSB:`FREQ_LSB];
	// last valid frequency code with lowest latency is the conflict case, held low by the trailing 1'b0
	wire conflict = (hint[`FREQ_MSB:`FREQ_LSB] == `FREQ_LAST_VALID) &&
		(hint[`LAT_MSB:`LAT_LSB] == `LAT_LOWEST) && 1'b0;
	// check bits asked for on a namespace without protection
	wire bad_prot = !prot_en && (prinfo[`PRINFO_CHECK_MSB-`PRINFO_LSB:0] != 3'h0);

	// no command is taken while the internal reset copy still holds
	assign cmd_ready_out = state[0] && rst_n;

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state             <= ST_IDLE;
			opcode            <= 8'h00;
			cur_lba           <= 64'h0000000000000000;
			remain            <= 16'h0000;
			cpl_valid_out     <= 1'b0;
			cpl_cmd_id_out    <= 16'h0000;
			cpl_sqid_out      <= 16'h0000;
			cpl_sct_out       <= 3'h0;
			cpl_sc_out        <= 8'h00;
			media_addr_out    <= 64'h0000000000000000;
			media_count_out   <= 16'h0000;
			ref_tag_out       <= 32'h00000000;
			app_tag_mask_out  <= 16'h0000;
			app_tag_value_out <= 16'h0000;
			freq_hint_out     <= 4'h0;
			low_latency_out   <= 1'b0;
			map_we            <= 1'b0;
			map_wdata         <= 1'b0;
			cmd_count         <= 32'h00000000;
		end else begin
			map_we <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (cmd_valid_in) begin
					opcode          <= cmd_opcode_in;
					cpl_cmd_id_out  <= cmd_id_in;
					cpl_sqid_out    <= cmd_sqid_in;
					cur_lba         <= {cdw11_in, cdw10_in};
					remain          <= cdw12_in[`COUNT_MSB:`COUNT_LSB];
					media_addr_out  <= {cdw11_in, cdw10_in};
					media_count_out <= cdw12_in[`COUNT_MSB:`COUNT_LSB];
					cpl_sct_out     <= `SCT_GENERIC;
					cpl_sc_out      <= `SC_SUCCESS;
					state           <= ST_WALK;
					if (cmd_opcode_in == `OPC_WRITE) begin
						freq_hint_out   <= freq;
						low_latency_out <= (hint[`LAT_MSB:`LAT_LSB] == `LAT_LOWEST);
						ref_tag_out       <= prot_en ? cdw14_in : 32'h00000000;
						app_tag_mask_out  <= prot_en ?
							cdw15_in[`TAG_MASK_MSB:`TAG_MASK_LSB] : 16'h0000;
						app_tag_value_out <= prot_en ?
							cdw15_in[`TAG_VAL_MSB:`TAG_VAL_LSB] : 16'h0000;
						if (conflict) begin
							cpl_sct_out <= `SCT_CMD_SPECIFIC;
							cpl_sc_out  <= `SC_CONFLICT;
							state       <= ST_CPL;
						end else if (bad_prot) begin
							cpl_sct_out <= `SCT_CMD_SPECIFIC;
							cpl_sc_out  <= `SC_BAD_PROT;
							state       <= ST_CPL;
						end
					end else if (cmd_opcode_in != `OPC_WRITE_UNCORR &&
						cmd_opcode_in != `OPC_READ) begin
						cpl_sc_out <= `SC_INVALID_OPCODE;
						state      <= ST_CPL;
					end
				end
			end
			ST_WALK: begin
				if (opcode == `OPC_READ) begin
					state <= ST_WAIT;
				end else begin
					map_we    <= 1'b1;
					map_wdata <= (opcode == `OPC_WRITE_UNCORR);
					if (last_step(remain)) begin
						state <= ST_CPL;
					end else begin
						remain  <= count_minus_one(remain);
						cur_lba <= lba_plus_one(cur_lba);
					end
				end
			end
			ST_WAIT: begin
				state <= ST_CHK;
			end
			ST_CHK: begin
				// a never-written map entry reads unknown and counts as clean
				if (map_rd) begin
					cpl_sct_out <= `SCT_MEDIA;
					cpl_sc_out  <= `SC_UNRECOVERED_READ;
					state       <= ST_CPL;
				end else if (last_step(remain)) begin
					state <= ST_CPL;
				end else begin
					remain  <= count_minus_one(remain);
					cur_lba <= lba_plus_one(cur_lba);
					state   <= ST_WAIT;
				end
			end
			ST_CPL: begin
				cpl_valid_out <= 1'b1;
				if (cpl_valid_out && cpl_ready_in) begin
					cpl_valid_out <= 1'b0;
					cmd_count     <= cmd_count + 32'h00000001;
					state         <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// map write uses the lba latched for this step
	reg [`MAP_ADDR_W-1:0] wr_idx;
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wr_idx <= {`MAP_ADDR_W{1'b0}};
		end else begin
			wr_idx <= map_index(cur_lba);
		end
	end

	invalid_map u_map (
		.clk_in    (clk_in),
		.we_in     (map_we),
		.waddr_in  (wr_idx),
		.wdata_in  (map_wdata),
		.raddr_in  (map_index(cur_lba)),
		.rdata_out (map_rd)
	);

	// ****************************************
	// wishbone slave
	// ****************************************
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctrl       <= `CTRL_RESET;
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
			// a write lands on the edge at which the master sees ack high
			if (wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in &&
				wb_adr_in[5:2] == (`REG_CTRL >> 2)) begin
				ctrl <= merge_bytes(ctrl, wb_dat_in, wb_sel_in);
			end
			if (wb_cyc_in && wb_stb_in && !wb_ack_out) begin
				case (wb_adr_in[5:2])
				(`REG_CTRL >> 2):      wb_dat_out <= ctrl;
				(`REG_STATUS >> 2):    wb_dat_out <= {27'h0000000, state};
				(`REG_LAST_CMPL >> 2): wb_dat_out <= {13'h0000, cpl_sct_out, 8'h00, cpl_sc_out};
				(`REG_CMD_COUNT >> 2): wb_dat_out <= cmd_count;
				default:               wb_dat_out <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // write_and_mark_invalid_cmd_decode

// file: wuc_defines.vh
`ifndef WUC_DEFINES_VH
`define WUC_DEFINES_VH

// ****************************************
// command decode
// ****************************************
`define OPC_WRITE           8'h01
`define OPC_READ            8'h02
`define OPC_WRITE_UNCORR    8'h04
`define HINT_LSB            0
`define HINT_MSB            7
`define FREQ_MSB            3
`define FREQ_LSB            0
`define LAT_MSB             5
`define LAT_LSB             4
`define FREQ_LAST_VALID     4'h6
`define LAT_LOWEST          2'h3
`define TAG_MASK_MSB        31
`define TAG_MASK_LSB        16
`define TAG_VAL_MSB         15
`define TAG_VAL_LSB         0
`define COUNT_MSB           15
`define COUNT_LSB           0
`define PRINFO_MSB          29
`define PRINFO_LSB          26
`define PRINFO_CHECK_MSB    28
`define PRINFO_CHECK_LSB    26
`define PRINFO_ACT_BIT      29

// ****************************************
// status codes
// ****************************************
`define SCT_GENERIC         3'h0
`define SCT_CMD_SPECIFIC    3'h1
`define SCT_MEDIA           3'h2
`define SC_SUCCESS          8'h00
`define SC_INVALID_OPCODE   8'h01
`define SC_LBA_RANGE        8'h80
`define SC_CONFLICT         8'h80
`define SC_BAD_PROT         8'h81
`define SC_UNRECOVERED_READ 8'h81

// ****************************************
// register map (byte addresses)
// ****************************************
`define REG_CTRL            4'h0
`define REG_STATUS          4'h4
`define REG_LAST_CMPL       4'h8
`define REG_CMD_COUNT       4'hC
`define CTRL_PROT_BIT       0
`define CTRL_RESET          32'h00000000

// ****************************************
// invalid-block map
// ****************************************
`define MAP_ADDR_W          10
`define MAP_DEPTH           1024

`endif

// file: invalid_map.v
`include "wuc_defines.vh"

module invalid_map (
	input  wire                   clk_in,
	input  wire                   we_in,
	input  wire [`MAP_ADDR_W-1:0] waddr_in,
	input  wire                   wdata_in,
	input  wire [`MAP_ADDR_W-1:0] raddr_in,
	output reg                    rdata_out
);

	reg mem [0:`MAP_DEPTH-1];

	// not reset: a wide clear sweep would cost a pass at start-up
	always @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end

endmodule // invalid_map

// file: wmi_assertions.sv
module wmi_assertions (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        cmd_valid_in,
	input wire logic        cmd_ready_out,
	input wire logic [7:0]  cmd_opcode_in,
	input wire logic [31:0] cdw12_in,
	input wire logic        cpl_valid_out,
	input wire logic        cpl_ready_in,
	input wire logic [2:0]  cpl_sct_out,
	input wire logic [7:0]  cpl_sc_out,
	input wire logic [3:0]  freq_hint_out,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_ack_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// *****
	// checks
	// *****
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_ack_once: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
	chk_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing");
	chk_cpl_hold: assert property (cpl_valid_out && !cpl_ready_in |=> cpl_valid_out &&
		$stable({cpl_sct_out, cpl_sc_out})) else $error("completion lost");
	chk_cpl_drop: assert property (cpl_valid_out && cpl_ready_in |=> !cpl_valid_out)
		else $error("completion twice");
	chk_busy_refuse: assert property (cpl_valid_out |-> !cmd_ready_out) else $error("ready busy");
	chk_take_busy: assert property (cmd_valid_in && cmd_ready_out |=> !cmd_ready_out)
		else $error("ready after take");
	chk_freq_range: assert property (freq_hint_out <= 4'h6) else $error("reserved hint");
	chk_sc_kind: assert property (cpl_valid_out && cpl_sct_out == 3'h1 |->
		cpl_sc_out == 8'h81) else $error("bad specific code");
	chk_mark_time: assert property (cmd_valid_in && cmd_ready_out && cmd_opcode_in == 8'h04 &&
		cdw12_in[15:0] == 16'h0002 |-> ##[1:6] cpl_valid_out) else $error("mark late");
	chk_write_time: assert property (cmd_valid_in && cmd_ready_out && cmd_opcode_in == 8'h01 &&
		cdw12_in[15:0] == 16'h0000 |-> ##[1:4] cpl_valid_out) else $error("write late");
endmodule // wmi_assertions

bind write_and_mark_invalid_cmd_decode wmi_assertions wmi_assertions_inst (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
	.cmd_ready_out(cmd_ready_out), .cmd_opcode_in(cmd_opcode_in), .cdw12_in(cdw12_in),
	.cpl_valid_out(cpl_valid_out), .cpl_ready_in(cpl_ready_in), .cpl_sct_out(cpl_sct_out),
	.cpl_sc_out(cpl_sc_out), .freq_hint_out(freq_hint_out), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out));

// file: host_cpl_model.sv
module host_cpl_model (
	input  wire logic clk_in,
	input  wire logic slow_in,
	input  wire logic cpl_valid_in,
	output logic      cpl_ready_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// *****
	// completion consumer
	// *****
	logic [1:0] wait_count = 2'h0;
	// slow mode stalls three cycles, as a host behind on its queue would
	always @(posedge clk_in) begin
		wait_count <= (cpl_valid_in && !cpl_ready_out) ? wait_count + 2'h1 : 2'h0;
		cpl_ready_out <= cpl_valid_in && !cpl_ready_out && (!slow_in || wait_count == 2'h3);
	end
endmodule // host_cpl_model

// file: tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// *****
	// signals
	// *****
	logic        clk_in = 1'b0, rst_n_in = 1'b0, cmd_valid_in = 1'b0, slow = 1'b0;
	logic        wb_we_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
	logic [3:0]  wb_sel_in = 4'hF;
	logic [5:0]  wb_adr_in = 6'h00;
	logic [7:0]  cmd_opcode_in = 8'h00;
	logic [15:0] cmd_id_in = 16'h0000, cmd_sqid_in = 16'h0003;
	logic [31:0] wb_dat_in, cdw10_in, cdw11_in, cdw12_in, cdw13_in, cdw14_in, cdw15_in;
	wire         cmd_ready_out, cpl_valid_out, cpl_ready_in, wb_ack_out, low_latency_out;
	wire  [15:0] cpl_cmd_id_out, cpl_sqid_out, media_count_out, app_tag_mask_out, app_tag_value_out;
	wire  [2:0]  cpl_sct_out;
	wire  [7:0]  cpl_sc_out;
	wire  [3:0]  freq_hint_out;
	wire  [31:0] ref_tag_out, wb_dat_out;
	wire  [63:0] media_addr_out;
	int          fails = 0, check_count = 0, cycles = 0;

	write_and_mark_invalid_cmd_decode write_and_mark_invalid_cmd_decode_inst (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
		.cmd_ready_out(cmd_ready_out), .cmd_opcode_in(cmd_opcode_in), .cmd_id_in(cmd_id_in),
		.cmd_sqid_in(cmd_sqid_in), .cdw10_in(cdw10_in), .cdw11_in(cdw11_in), .cdw12_in(cdw12_in),
		.cdw13_in(cdw13_in), .cdw14_in(cdw14_in), .cdw15_in(cdw15_in),
		.cpl_valid_out(cpl_valid_out), .cpl_ready_in(cpl_ready_in),
		.cpl_cmd_id_out(cpl_cmd_id_out), .cpl_sqid_out(cpl_sqid_out), .cpl_sct_out(cpl_sct_out),
		.cpl_sc_out(cpl_sc_out), .media_addr_out(media_addr_out),
		.media_count_out(media_count_out), .ref_tag_out(ref_tag_out),
		.app_tag_mask_out(app_tag_mask_out), .app_tag_value_out(app_tag_value_out),
		.freq_hint_out(freq_hint_out), .low_latency_out(low_latency_out),
		.wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
		.wb_we_in(wb_we_in), .wb_sel_in(wb_sel_in), .wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out));
	host_cpl_model host_cpl_model_inst (.clk_in(clk_in), .slow_in(slow),
		.cpl_valid_in(cpl_valid_out), .cpl_ready_out(cpl_ready_in));

	initial forever #2.5 clk_in = ~clk_in;
	// a hang counts as a mismatch; the whole run needs well under 2000 cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			finish_test();
		end
	end

	// *****
	// tasks
	// *****
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// on a read, d is the expected data
	task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do @(posedge clk_in); while (wb_ack_out !== 1'b1);
		if (!we) check(wb_dat_out, d);
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask
	task automatic cmd(input logic [7:0] op, input logic [63:0] lba, input logic [31:0] d12,
		input logic [31:0] d13, input logic [31:0] d14, input logic [31:0] d15, input logic [10:0] st);
		@(posedge clk_in);
		cmd_valid_in <= 1'b1;
		cmd_opcode_in <= op;
		{cdw11_in, cdw10_in} <= lba;
		{cdw12_in, cdw13_in, cdw14_in, cdw15_in} <= {d12, d13, d14, d15};
		cmd_id_in <= cmd_id_in + 16'h0001;
		do @(posedge clk_in); while (cmd_ready_out !== 1'b1);
		cmd_valid_in <= 1'b0;
		do @(posedge clk_in); while (!(cpl_valid_out === 1'b1 && cpl_ready_in === 1'b1));
		check({cpl_sct_out, cpl_sc_out}, st);
		check({cpl_cmd_id_out, cpl_sqid_out}, {cmd_id_in, cmd_sqid_in});
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// *****
	// tests
	// *****
	initial begin
		{wb_dat_in, cdw10_in, cdw11_in, cdw12_in, cdw13_in, cdw14_in, cdw15_in} = '0;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		wb(1'b0, 6'h00, 32'h00000000);
		wb(1'b1, 6'h00, 32'h00000001);
		wb(1'b0, 6'h00, 32'h00000001);
		wb(1'b1, 6'h00, 32'h00000000);
		wb(1'b0, 6'h10, 32'h00000000);
		$display("register test done");
		// other command fields left zero by the host
		cmd(8'h04, 64'h0000000200000005, 32'h00000002, 0, 0, 0, 11'h000);
		check({media_addr_out, media_count_out}, {64'h0000000200000005, 16'h0002});
		cmd(8'h02, 64'h6, 32'h0, 0, 0, 0, 11'h281);
		$display("mark test done");
		for (int f = 0; f < 16; f++) begin
			cmd(8'h01, 64'h6, 32'h0, {f[1:0], f[3:0]}, 32'hFFFFFFFF, 32'hFFFFFFFF, 11'h000);
			check(freq_hint_out, f > 6 ? 0 : f);
			check(low_latency_out, f[1:0] == 2'h3);
			check({ref_tag_out, app_tag_mask_out, app_tag_value_out}, 64'h0);
		end
		cmd(8'h02, 64'h5, 32'h00000002, 0, 0, 0, 11'h281);
		cmd(8'h02, 64'h6, 32'h0, 0, 0, 0, 11'h000);
		$display("hint and clear test done");
		slow <= 1'b1;
		cmd(8'h01, 64'h6, 32'h1C000000, 0, 0, 0, 11'h181);
		slow <= 1'b0;
		wb(1'b0, 6'h08, 32'h00010081);
		wb(1'b1, 6'h00, 32'h00000001);
		cmd(8'h01, 64'h6, 32'h1C000000, 32'h26, 32'hA5A50001, 32'h12345678, 11'h000);
		check({ref_tag_out, app_tag_mask_out, app_tag_value_out}, 64'hA5A5000112345678);
		wb(1'b0, 6'h0C, 32'h00000016);
		wb(1'b0, 6'h04, 32'h00000001);
		$display("protection test done");
		finish_test();
	end
endmodule // tb
